// ==== hw/pifr_pkg.sv ====
package pifr_pkg;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // width of each peripheral source register folded into a summary flag
  localparam int SRC_W = 8;

  // flag register offsets
  localparam logic [ADDR_W-1:0] PIFR5_OFS = 12'h4B3;
  localparam logic [ADDR_W-1:0] PIFR6_OFS = 12'h4B4;
  localparam logic [ADDR_W-1:0] PIFR7_OFS = 12'h4B5;
  localparam logic [ADDR_W-1:0] PIFR8_OFS = 12'h4B6;
  // interrupt status and mask offsets
  localparam logic [ADDR_W-1:0] ISTAT_OFS = 12'h4C0;
  localparam logic [ADDR_W-1:0] IMASK_OFS = 12'h4C1;

  // reset values
  localparam logic [DATA_W-1:0] FLAG_RST = 8'h00;
  localparam logic [DATA_W-1:0] IMASK_RST = 8'h00;

  // flag register 5 tail, read-only summaries and levels
  localparam int R5_P2PARAM_BIT = 7;
  localparam int R5_S2SUM_BIT = 2;
  localparam int R5_S2TX_BIT = 1;
  localparam int R5_S2RX_BIT = 0;

  // flag register 7 fields
  localparam int R7_P3PARAM_BIT = 7;
  localparam int R7_P3PER_BIT = 6;
  localparam int R7_LC3_BIT = 5;
  localparam int R7_UNUSED_BIT = 4;
  localparam int R7_TWERR_BIT = 3;
  localparam int R7_TWSUM_BIT = 2;
  localparam int R7_TWTX_BIT = 1;
  localparam int R7_TWRX_BIT = 0;

  // flag register 8 fields
  localparam int R8_SCAN_BIT = 7;
  localparam int R8_CC2_BIT = 6;
  localparam int R8_T5G_BIT = 5;
  localparam int R8_T5_BIT = 4;
  localparam int R8_U2SUM_BIT = 3;
  localparam int R8_U2FE_BIT = 2;
  localparam int R8_U2TX_BIT = 1;
  localparam int R8_U2RX_BIT = 0;

  // software-writable (hardware-set) positions per register
  localparam logic [DATA_W-1:0] R6_WMASK = 8'hFF;
  localparam logic [DATA_W-1:0] R7_WMASK = 8'h60;
  localparam logic [DATA_W-1:0] R8_WMASK = 8'hF0;

  // interrupt status bit per flag register
  localparam int IST_R5_BIT = 0;
  localparam int IST_R6_BIT = 1;
  localparam int IST_R7_BIT = 2;
  localparam int IST_R8_BIT = 3;
  localparam int IST_W = 4;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic [DATA_W-1:0] flags6_set;
    logic pulse3_period;
    logic logic_cell3;
    logic twowire1_tx;
    logic twowire1_rx;
    logic twowire1_buf_clear;
    logic mem_scanner;
    logic capcomp2;
    logic timer5_gate;
    logic timer5;
  } pifr_evt_type;

  // level state held inside the peripherals
  typedef struct packed {
    logic [SRC_W-1:0] pulse_unit2_group_irq_reg;
    logic [SRC_W-1:0] serial_if2_irq_reg;
    logic [SRC_W-1:0] pulse_unit3_group_irq_reg;
    logic [SRC_W-1:0] twowire1_error_reg;
    logic [SRC_W-1:0] twowire1_protocol_irq_reg;
    logic [SRC_W-1:0] uart2_general_irq_reg;
    logic [SRC_W-1:0] uart2_error_reg;
    logic serial_if2_tx;
    logic serial_if2_rx;
    logic uart2_tx;
    logic uart2_rx;
  } pifr_src_type;

  // flag register images toward the vectoring logic
  typedef struct packed {
    logic [DATA_W-1:0] periph_irq_flags_5;
    logic [DATA_W-1:0] periph_irq_flags_6;
    logic [DATA_W-1:0] periph_irq_flags_7;
    logic [DATA_W-1:0] periph_irq_flags_8;
  } pifr_flags_type;

endpackage

// ==== hw/pifr_sticky.sv ====
`timescale 1ns/100ps
`default_nettype none

// bank of hardware-set, software-written flags; non-writable positions stay zero
module pifr_sticky import pifr_pkg::*; #(
  parameter int W = DATA_W,
  parameter logic [W-1:0] WMASK = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // hardware set and software write
  input wire logic [W-1:0] set_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  // flag state
  output logic [W-1:0] q_o
);

  // refuse widths the bank cannot serve, at elaboration
  if (W < 1 || W > DATA_W) begin : g_bad_width
    $error("pifr_sticky: width out of range");
  end

  // one flop per writable position
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (WMASK[i]) begin : g_flag
      logic flag_r;
      logic flag_nxt;
      // a set in the cycle of a zero write wins so no event is lost
      assign flag_nxt = set_i[i] | (wr_i ? wdata_i[i] : flag_r);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_r <= FLAG_RST[i];
        end else begin
          flag_r <= flag_nxt;
        end
      end
      assign q_o[i] = flag_r;
    end else begin : g_none
      assign q_o[i] = 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== hw/pifr_top.sv ====
// Function
// - flags set on their event regardless of any enable bit
// - hardware-set read/write flags hold one until software writes zero
// - pulse unit 2 parameter flag is read-only, high while its group register nonzero
// - serial interface 2 summary flag read-only, falls once its flag register clears
// - serial interface 2 tx and rx flags read-only, writes cannot change them
// - register six holds dma2, osc1, waveform1, logic cell2, ext irq1 flags
// - register seven layout, bit 4 unused, twowire flags read-only
// - pulse unit 3 parameter flag read-only, clears once group register clears
// - twowire1 error flag read-only, falls once its error register clears
// - twowire1 summary flag read-only, falls once protocol register clears
// - twowire1 tx and rx flags read-only, cleared by buffer clear bit
// - register eight layout, upper nibble writable, lower nibble read-only
// - uart2 summary flag read-only, falls once general register clears
// - uart2 framing flag read-only, falls once error register clears
// - uart2 tx and rx flags read-only, writes cannot change them
`timescale 1ns/100ps
`default_nettype none

module pifr_top import pifr_pkg::*; (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  // peripheral side
  input wire pifr_evt_type EVT_I,
  input wire pifr_src_type SRC_I,
  // flag images and interrupt
  output var pifr_flags_type FLAGS_O,
  output logic IRQ_O
);

  // address decode
  wire hit5 = (ADDR_I == PIFR5_OFS);
  wire hit6 = (ADDR_I == PIFR6_OFS);
  wire hit7 = (ADDR_I == PIFR7_OFS);
  wire hit8 = (ADDR_I == PIFR8_OFS);
  wire hit_stat = (ADDR_I == ISTAT_OFS);
  wire hit_mask = (ADDR_I == IMASK_OFS);
  // register 5 has no writable bit, so its writes go nowhere
  wire wr6 = WR_I & hit6;
  wire wr7 = WR_I & hit7;
  wire wr8 = WR_I & hit8;
  wire wr_mask = WR_I & hit_mask;
  wire rd_stat = RD_I & hit_stat;

  // hardware-set vectors placed at their bit positions
  logic [DATA_W-1:0] set7;
  logic [DATA_W-1:0] set8;
  always_comb begin
    set7 = '0;
    set7[R7_P3PER_BIT] = EVT_I.pulse3_period;
    set7[R7_LC3_BIT] = EVT_I.logic_cell3;
    set8 = '0;
    set8[R8_SCAN_BIT] = EVT_I.mem_scanner;
    set8[R8_CC2_BIT] = EVT_I.capcomp2;
    set8[R8_T5G_BIT] = EVT_I.timer5_gate;
    set8[R8_T5_BIT] = EVT_I.timer5;
  end

  logic [DATA_W-1:0] r6_q;
  logic [DATA_W-1:0] r7_q;
  logic [DATA_W-1:0] r8_q;

  pifr_sticky #(.W(DATA_W), .WMASK(R6_WMASK)) u_flags6 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .set_i(EVT_I.flags6_set),
    .wr_i(wr6),
    .wdata_i(WDATA_I),
    .q_o(r6_q)
  );

  // only bits 6 and 5 take writes
  pifr_sticky #(.W(DATA_W), .WMASK(R7_WMASK)) u_flags7 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .set_i(set7),
    .wr_i(wr7),
    .wdata_i(WDATA_I),
    .q_o(r7_q)
  );

  // only the upper nibble takes writes
  pifr_sticky #(.W(DATA_W), .WMASK(R8_WMASK)) u_flags8 (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .set_i(set8),
    .wr_i(wr8),
    .wdata_i(WDATA_I),
    .q_o(r8_q)
  );

  // read-only flags mirror peripheral state one cycle late
  logic [DATA_W-1:0] ro5_r;
  logic [DATA_W-1:0] ro5_nxt;
  logic [DATA_W-1:0] ro7_r;
  logic [DATA_W-1:0] ro7_nxt;
  logic [DATA_W-1:0] ro8_r;
  logic [DATA_W-1:0] ro8_nxt;
  always_comb begin
    ro5_nxt = '0;
    ro5_nxt[R5_P2PARAM_BIT] = |SRC_I.pulse_unit2_group_irq_reg;
    ro5_nxt[R5_S2SUM_BIT] = |SRC_I.serial_if2_irq_reg;
    ro5_nxt[R5_S2TX_BIT] = SRC_I.serial_if2_tx;
    ro5_nxt[R5_S2RX_BIT] = SRC_I.serial_if2_rx;
    ro7_nxt = '0;
    ro7_nxt[R7_P3PARAM_BIT] = |SRC_I.pulse_unit3_group_irq_reg;
    ro7_nxt[R7_TWERR_BIT] = |SRC_I.twowire1_error_reg;
    ro7_nxt[R7_TWSUM_BIT] = |SRC_I.twowire1_protocol_irq_reg;
    // held until buffer clear, a new event wins
    ro7_nxt[R7_TWTX_BIT] = EVT_I.twowire1_tx |
                           (ro7_r[R7_TWTX_BIT] & ~EVT_I.twowire1_buf_clear);
    ro7_nxt[R7_TWRX_BIT] = EVT_I.twowire1_rx |
                           (ro7_r[R7_TWRX_BIT] & ~EVT_I.twowire1_buf_clear);
    ro8_nxt = '0;
    ro8_nxt[R8_U2SUM_BIT] = |SRC_I.uart2_general_irq_reg;
    ro8_nxt[R8_U2FE_BIT] = |SRC_I.uart2_error_reg;
    ro8_nxt[R8_U2TX_BIT] = SRC_I.uart2_tx;
    ro8_nxt[R8_U2RX_BIT] = SRC_I.uart2_rx;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ro5_r <= FLAG_RST;
      ro7_r <= FLAG_RST;
      ro8_r <= FLAG_RST;
    end else begin
      ro5_r <= ro5_nxt;
      ro7_r <= ro7_nxt;
      ro8_r <= ro8_nxt;
    end
  end

  // full register images; writable and read-only positions never overlap
  wire [DATA_W-1:0] f5 = ro5_r;
  wire [DATA_W-1:0] f6 = r6_q;
  wire [DATA_W-1:0] f7 = r7_q | ro7_r;
  wire [DATA_W-1:0] f8 = r8_q | ro8_r;

  // a register raises its status bit when any of its flags rises
  logic [DATA_W-1:0] prev5_r;
  logic [DATA_W-1:0] prev6_r;
  logic [DATA_W-1:0] prev7_r;
  logic [DATA_W-1:0] prev8_r;
  logic [IST_W-1:0] rise;
  always_comb begin
    rise = '0;
    rise[IST_R5_BIT] = |(f5 & ~prev5_r);
    rise[IST_R6_BIT] = |(f6 & ~prev6_r);
    rise[IST_R7_BIT] = |(f7 & ~prev7_r);
    rise[IST_R8_BIT] = |(f8 & ~prev8_r);
  end

  // status clears on read, but a rise in that same cycle survives
  logic [IST_W-1:0] istat_r;
  logic [IST_W-1:0] istat_nxt;
  logic [IST_W-1:0] imask_r;
  logic [IST_W-1:0] imask_nxt;
  assign istat_nxt = (rd_stat ? '0 : istat_r) | rise;
  assign imask_nxt = wr_mask ? WDATA_I[IST_W-1:0] : imask_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prev5_r <= FLAG_RST;
      prev6_r <= FLAG_RST;
      prev7_r <= FLAG_RST;
      prev8_r <= FLAG_RST;
      istat_r <= '0;
      imask_r <= IMASK_RST[IST_W-1:0];
    end else begin
      prev5_r <= f5;
      prev6_r <= f6;
      prev7_r <= f7;
      prev8_r <= f8;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
    end
  end

  // read selection; unmapped addresses read zero
  wire [DATA_W-1:0] stat_word = {{(DATA_W-IST_W){1'b0}}, istat_r};
  wire [DATA_W-1:0] mask_word = {{(DATA_W-IST_W){1'b0}}, imask_r};
  wire [DATA_W-1:0] rd_mux = hit5 ? f5 :
                             hit6 ? f6 :
                             hit7 ? f7 :
                             hit8 ? f8 :
                             hit_stat ? stat_word :
                             hit_mask ? mask_word : '0;

  // output flops; read data stand only in the cycle after the strobe
  logic [DATA_W-1:0] rdata_r;
  logic irq_r;
  pifr_flags_type flags_r;
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_r <= '0;
      irq_r <= 1'b0;
      flags_r <= '0;
    end else begin
      rdata_r <= RD_I ? rd_mux : '0;
      irq_r <= |(istat_nxt & imask_nxt);
      flags_r <= {f5, f6, f7, f8};
    end
  end
  assign RDATA_O = rdata_r;
  assign IRQ_O = irq_r;
  assign FLAGS_O = flags_r;

  // checks on the design's own behaviour
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_SET_NO_ENABLE: assert property (
    (|EVT_I.flags6_set) |=> ((r6_q & $past(EVT_I.flags6_set)) == $past(EVT_I.flags6_set)))
    else $error("register six flag missed its event");
  AST_STICKY_HOLD: assert property (
    !wr6 |=> ((r6_q & $past(r6_q)) == $past(r6_q)))
    else $error("register six flag dropped without a write");
  AST_ZERO_WRITE: assert property (
    (wr6 && EVT_I.flags6_set == '0) |=> (r6_q == $past(WDATA_I)))
    else $error("register six write not stored");
  AST_P2_SUMMARY: assert property (
    (|SRC_I.pulse_unit2_group_irq_reg) |=> ##1 FLAGS_O.periph_irq_flags_5[R5_P2PARAM_BIT])
    else $error("pulse unit two summary not raised");
  AST_S2_SUMMARY: assert property (
    (SRC_I.serial_if2_irq_reg == '0)[*2] |-> !ro5_r[R5_S2SUM_BIT])
    else $error("serial two summary high with clear source");
  AST_S2_LEVELS: assert property (
    (WR_I && hit5) |=> (ro5_r[R5_S2TX_BIT] == $past(SRC_I.serial_if2_tx)))
    else $error("serial two tx flag moved by a write");
  AST_R6_READ: assert property (
    (RD_I && hit6) |=> (RDATA_O == $past(r6_q)))
    else $error("register six read data wrong");
  AST_R7_WRITE: assert property (
    (wr7 && !EVT_I.pulse3_period && !EVT_I.logic_cell3) |=>
      (r7_q == ($past(WDATA_I) & R7_WMASK)))
    else $error("register seven write layout wrong");
  AST_P3_SUMMARY: assert property (
    (SRC_I.pulse_unit3_group_irq_reg != '0) |=> ro7_r[R7_P3PARAM_BIT])
    else $error("pulse unit three summary not raised");
  AST_TW_ERROR: assert property (
    (SRC_I.twowire1_error_reg == '0) |=> !ro7_r[R7_TWERR_BIT])
    else $error("twowire error flag high with clear source");
  AST_TW_SUMMARY: assert property (
    (SRC_I.twowire1_protocol_irq_reg != '0) |=> ro7_r[R7_TWSUM_BIT])
    else $error("twowire summary not raised");
  AST_TW_BUF_CLEAR: assert property (
    (EVT_I.twowire1_buf_clear && !EVT_I.twowire1_tx && !EVT_I.twowire1_rx) |=>
      (!ro7_r[R7_TWTX_BIT] && !ro7_r[R7_TWRX_BIT]))
    else $error("buffer clear left twowire tx or rx set");
  AST_R8_WRITE: assert property (
    (wr8 && set8 == '0) |=> (r8_q == ($past(WDATA_I) & R8_WMASK)))
    else $error("register eight write layout wrong");
  AST_U2_SUMMARY: assert property (
    (SRC_I.uart2_general_irq_reg == '0) |=> !ro8_r[R8_U2SUM_BIT])
    else $error("uart two summary high with clear source");
  AST_U2_FRAMING: assert property (
    (SRC_I.uart2_error_reg != '0) |=> ro8_r[R8_U2FE_BIT])
    else $error("uart two framing flag not raised");
  AST_S2_RX_LEVEL: assert property (
    (WR_I && hit5) |=> (ro5_r[R5_S2RX_BIT] == $past(SRC_I.serial_if2_rx)))
    else $error("serial two rx flag moved by a write");
  AST_TW_HOLD: assert property (
    (ro7_r[R7_TWTX_BIT] && !EVT_I.twowire1_buf_clear) |=> ro7_r[R7_TWTX_BIT])
    else $error("twowire tx flag dropped without buffer clear");
  AST_RDATA_IDLE: assert property (
    !RD_I |=> (RDATA_O == '0))
    else $error("read data not zero outside the read answer cycle");
  AST_U2_LEVELS: assert property (
    wr8 |=> (ro8_r[R8_U2RX_BIT] == $past(SRC_I.uart2_rx)))
    else $error("uart two rx flag moved by a write");
  AST_UNUSED_ZERO: assert property (
    (RD_I && hit7) |=> !RDATA_O[R7_UNUSED_BIT])
    else $error("unused bit of register seven reads one");
  AST_IRQ_LEVEL: assert property (
    (istat_r & imask_r) != '0 |-> IRQ_O)
    else $error("interrupt low with unmasked status set");

  COV_STICKY_CLEAR: cover property (r6_q[0] ##1 wr6 ##1 !r6_q[0]);
  COV_BUF_CLEAR: cover property (ro7_r[R7_TWTX_BIT] ##1 EVT_I.twowire1_buf_clear);
  COV_IRQ_READ: cover property (IRQ_O ##1 rd_stat ##2 !IRQ_O);
  COV_SET_ON_CLEAR: cover property (wr6 && EVT_I.flags6_set[0] && !WDATA_I[0]);

endmodule

`default_nettype wire

// ==== tb/pifr_periph_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// stand-in for the peripherals: event pulses and held source levels
module pifr_periph_model import pifr_pkg::*; (
  // clock
  input wire logic clk_i,
  // toward the flag block
  output var pifr_evt_type evt_o,
  output var pifr_src_type src_o
);
  // quiet at time zero
  initial begin
    evt_o = '0;
    src_o = '0;
  end

  // one-cycle pulse, launched and dropped right after edges
  task automatic fire(input pifr_evt_type e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= '0;
  endtask

  // source levels only move right after an edge
  task automatic set_src(input pifr_src_type s);
    @(posedge clk_i);
    src_o <= s;
  endtask
endmodule
`default_nettype wire

// ==== tb/pifr_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module pifr_top_tb import pifr_pkg::*;;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  pifr_evt_type evt;
  pifr_src_type src;
  pifr_flags_type flags;
  logic irq;
  int error_cnt;
  int checks_done;
  logic [DATA_W-1:0] d;
  pifr_evt_type e;
  pifr_src_type s;
  logic [ADDR_W-1:0] sum_addr [7] = '{PIFR5_OFS, PIFR5_OFS, PIFR7_OFS, PIFR7_OFS,
    PIFR7_OFS, PIFR8_OFS, PIFR8_OFS};
  int sum_bit [7] = '{R5_P2PARAM_BIT, R5_S2SUM_BIT, R7_P3PARAM_BIT, R7_TWERR_BIT,
    R7_TWSUM_BIT, R8_U2SUM_BIT, R8_U2FE_BIT};
  logic [DATA_W-1:0] src_val [3] = '{8'h81, 8'h01, 8'h00};
  logic [DATA_W-1:0] sum_exp [3] = '{8'h01, 8'h01, 8'h00};

  // 250 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // block under test and its peripheral side
  pifr_top pifr_top_i (
    .CLK_I(clk),
    .SYS_RST_I(rst),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .EVT_I(evt),
    .SRC_I(src),
    .FLAGS_O(flags),
    .IRQ_O(irq)
  );
  pifr_periph_model pifr_periph_model_i (
    .clk_i(clk),
    .evt_o(evt),
    .src_o(src)
  );

  // compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] v;
    reg_rd(a, v);
    check(v, exp);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t run did not finish", $time);
    final_report();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // whole map plus unmapped tail reads zero after reset
    for (int i = 0; i < 16; i++) begin
      rd_chk(PIFR5_OFS + ADDR_W'(i), FLAG_RST);
    end
    @(negedge clk);
    check(rdata, 8'h00);
    $display("test reset done");
    // register six: every source, mask left at zero
    for (int i = 0; i < 8; i++) begin
      e = '0;
      e.flags6_set[i] = 1'b1;
      pifr_periph_model_i.fire(e);
      rd_chk(PIFR6_OFS, 8'((1 << (i + 1)) - 1));
    end
    check(flags.periph_irq_flags_6, 8'hFF);
    reg_wr(PIFR6_OFS, 8'h7F);
    rd_chk(PIFR6_OFS, 8'h7F);
    reg_wr(PIFR6_OFS, 8'hA5);
    rd_chk(PIFR6_OFS, 8'hA5);
    $display("test reg6 done");
    // period, logic cell 3, scanner, capcomp 2, timer 5 gate and timer 5
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_018F));
    rd_chk(PIFR7_OFS, 8'h60);
    rd_chk(PIFR8_OFS, 8'hF0);
    check(flags.periph_irq_flags_8, 8'hF0);
    reg_wr(PIFR7_OFS, 8'h00);
    reg_wr(PIFR8_OFS, 8'h00);
    rd_chk(PIFR7_OFS, 8'h00);
    rd_chk(PIFR8_OFS, 8'h00);
    reg_wr(PIFR7_OFS, 8'hFF);
    rd_chk(PIFR7_OFS, 8'h60);
    reg_wr(PIFR5_OFS, 8'hFF);
    rd_chk(PIFR5_OFS, 8'h00);
    reg_wr(12'h4C2, 8'hFF);
    rd_chk(12'h4C2, 8'h00);
    $display("test writable masks done");
    // two-wire tx and rx: only the buffer clear drops them, a set wins
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_0060));
    reg_wr(PIFR7_OFS, 8'h00);
    rd_chk(PIFR7_OFS, 8'h03);
    check(flags.periph_irq_flags_7, 8'h03);
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_0010));
    rd_chk(PIFR7_OFS, 8'h00);
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_0070));
    rd_chk(PIFR7_OFS, 8'h03);
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_0010));
    $display("test buffer clear done");
    // summaries stay up until the whole source register is clear
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 3; k++) begin
        s = '0;
        s[$bits(s) - 1 - 8 * i -: 8] = src_val[k];
        pifr_periph_model_i.set_src(s);
        reg_rd(sum_addr[i], d);
        check(8'(d[sum_bit[i]]), sum_exp[k]);
      end
    end
    // tx and rx levels ignore software
    s = '0;
    s[3:0] = 4'hF;
    pifr_periph_model_i.set_src(s);
    reg_wr(PIFR5_OFS, 8'h00);
    reg_wr(PIFR8_OFS, 8'h00);
    rd_chk(PIFR5_OFS, 8'h03);
    check(flags.periph_irq_flags_5, 8'h03);
    rd_chk(PIFR8_OFS, 8'h03);
    pifr_periph_model_i.set_src('0);
    reg_wr(PIFR8_OFS, 8'h0F);
    rd_chk(PIFR8_OFS, 8'h00);
    $display("test summaries done");
    // clear everything before unmasking register six
    reg_wr(PIFR6_OFS, 8'h00);
    reg_rd(ISTAT_OFS, d);
    rd_chk(ISTAT_OFS, 8'h00);
    reg_wr(IMASK_OFS, 8'h02);
    rd_chk(IMASK_OFS, 8'h02);
    e = '0;
    e.flags6_set = 8'h01;
    pifr_periph_model_i.fire(e);
    repeat (2) @(negedge clk);
    check({7'h00, irq}, 8'h01);
    rd_chk(ISTAT_OFS, 8'h02);
    repeat (2) @(negedge clk);
    check({7'h00, irq}, 8'h00);
    // masked register eight still latches status
    pifr_periph_model_i.fire(pifr_evt_type'(17'h0_0001));
    repeat (2) @(negedge clk);
    check({7'h00, irq}, 8'h00);
    rd_chk(ISTAT_OFS, 8'h08);
    $display("test interrupt done");
    // reset again in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(PIFR6_OFS, FLAG_RST);
    check({7'h00, irq}, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
